// [shared/multi_port_io_pkg.sv]
// Summary of operation
// [R1] Software must set third-port bit 2 direction.
// [R2] Reset leaves third-port bit 2 inaccessible.
// [R3] Access pin high: third port cleared to 00H.
// [R4] Access pin low: third port bit 1 secondary.
// [R5] Third-port read: pin if input, else latch.
// [R6] Read-modify-write uses read selection, writes latch.
// [R7] Fourth port: output bits drive latch value.
// [R8] Fourth port secondary output carries memory address.
// [R9] Input with function select enables pull-up.
// [R10] Fourth port resets 00H or FFH by access pin.
// [R11] Fourth-port read: pin if input, else latch.
// [R12] Sixth port drives latch when output, select clear.
// [R13] Sixth-port inputs feed the external interrupt lines.
// [R14] Sixth port secondary output drives constant zero.
// [R15] Sixth port always resets to 00H input.
// [R16] Sixth-port read: pin, latch, or zero.
// [R17] Four reset sources all initialise port registers.
// [R18] Unimplemented register bits read as zero.
// [R19] Access pin level is sampled during reset.
package multi_port_io_pkg;

   localparam logic [7:0] OFS_P3_DATA = 8'h00;
   localparam logic [7:0] OFS_P3_DIR = 8'h04;
   localparam logic [7:0] OFS_P3_FSEL = 8'h08;
   localparam logic [7:0] OFS_P4_DATA = 8'h0c;
   localparam logic [7:0] OFS_P4_DIR = 8'h10;
   localparam logic [7:0] OFS_P4_FSEL = 8'h14;
   localparam logic [7:0] OFS_P6_DATA = 8'h18;
   localparam logic [7:0] OFS_P6_DIR = 8'h1c;
   localparam logic [7:0] OFS_P6_FSEL = 8'h20;
   localparam logic [7:0] OFS_P3_RMW = 8'h24;
   localparam logic [7:0] OFS_P4_RMW = 8'h28;
   localparam logic [7:0] OFS_P6_RMW = 8'h2c;
   localparam logic [7:0] OFS_STATUS = 8'h30;

   // Implemented bit masks; all other positions read as zero.
   localparam logic [7:0] P3_MASK = 8'h0e;
   localparam logic [7:0] P4_MASK = 8'hff;
   localparam logic [7:0] P6_MASK = 8'h0f;

   localparam int P3_GUARDED_BIT = 2;

   localparam logic [7:0] RST_ZERO = 8'h00;
   localparam logic [7:0] P3_RST_EA_LOW = 8'h02;
   localparam logic [7:0] P4_RST_EA_LOW = 8'hff;

   // Read-modify-write command word: mask in the low byte, operation above.
   localparam int RMW_OP_LSB = 8;
   localparam logic [1:0] RMW_OR = 2'h0;
   localparam logic [1:0] RMW_ANDN = 2'h1;
   localparam logic [1:0] RMW_XOR = 2'h2;
   localparam logic [1:0] RMW_ADD = 2'h3;

   localparam int STAT_EA_BIT = 0;
   localparam int STAT_P3_LOCK_BIT = 1;

   typedef struct packed {
      logic [7:0] out;
      logic [7:0] oe;
      logic [7:0] pull_up;
   } pin_drive_t;

   typedef struct packed {
      logic [7:0] data;
      logic [7:0] dir;
      logic [7:0] fsel;
   } port_regs_t;

endpackage

// [rtl/multi_port_io_block.sv]
// Decided for this implementation: the register addresses and register access over APB.
module multi_port_io_block
   import multi_port_io_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic break_instruction,
   input wire logic watchdog_overflow,
   input wire logic opcode_trap,
   input wire logic external_access_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [7:0] port_three_pin_in,
   input wire logic [7:0] port_three_alt_out,
   output pin_drive_t port_three_pins,
   input wire logic [7:0] port_four_pin_in,
   input wire logic [7:0] ext_mem_addr,
   output pin_drive_t port_four_pins,
   input wire logic [7:0] port_six_pin_in,
   output pin_drive_t port_six_pins,
   output logic ext_interrupt_in_zero,
   output logic ext_interrupt_in_one,
   output logic ext_interrupt_in_two,
   output logic ext_interrupt_in_three
);

   port_regs_t p3_reg;
   port_regs_t p4_reg;
   port_regs_t p6_reg;
   logic init_pending_reg;
   logic ea_sample_reg;
   logic [31:0] prdata_reg;
   logic sync_reset;
   logic reset_load;
   logic ea_level;
   logic wr_en;
   logic [7:0] p3_read;
   logic [7:0] p4_read;
   logic [7:0] p6_read;
   logic [7:0] rd_sel;
   logic rd_hit;

   // Per-bit read selection; zero_on_alt returns 0 where both dir and fsel are set.
   function automatic logic [7:0] port_read(input logic [7:0] pin, input port_regs_t r,
                                            input logic [7:0] mask, input logic zero_on_alt);
      logic [7:0] v;
      v = (pin & ~r.dir) | (r.data & r.dir);
      if (zero_on_alt)
      begin
         v = v & ~(r.dir & r.fsel);
      end
      return v & mask;
   endfunction

   function automatic logic [7:0] rmw_result(input logic [7:0] cur, input logic [31:0] cmd,
                                             input logic [7:0] mask);
      logic [7:0] m;
      logic [7:0] r;
      m = cmd[7:0];
      case (cmd[RMW_OP_LSB +: 2])
         RMW_OR: r = cur | m;
         RMW_ANDN: r = cur & ~m;
         RMW_XOR: r = cur ^ m;
         RMW_ADD: r = 8'(cur + m);
         default: r = cur;
      endcase
      return r & mask;
   endfunction

   function automatic port_regs_t reset_value(input logic [7:0] dir_fsel);
      port_regs_t v;
      v.data = RST_ZERO;
      v.dir = dir_fsel;
      v.fsel = dir_fsel;
      return v;
   endfunction

   // The break, watchdog and trap sources arrive as synchronous pulses.
   assign sync_reset = break_instruction | watchdog_overflow | opcode_trap; // [R17]
   assign reset_load = init_pending_reg | sync_reset; // [R17]
   assign ea_level = init_pending_reg ? ea_sample_reg : external_access_pin;
   assign wr_en = psel & penable & pwrite;

   // Without an async reset this flop keeps following the pin while reset is held,
   // so the value used at release was captured cleanly by a clocked process.
   always_ff @(posedge ref_clk)
   begin
      if (rst | init_pending_reg | sync_reset)
      begin
         ea_sample_reg <= external_access_pin; // [R19]
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         init_pending_reg <= 1'b1;
      end
      else
      begin
         init_pending_reg <= 1'b0;
      end
   end

   assign p3_read = port_read(port_three_pin_in, p3_reg, P3_MASK, 1'b0); // [R5] [R18]
   assign p4_read = port_read(port_four_pin_in, p4_reg, P4_MASK, 1'b0); // [R11]
   assign p6_read = port_read(port_six_pin_in, p6_reg, P6_MASK, 1'b1); // [R16] [R18]

   // Third port: the async reset clears everything, which already leaves bit 2 of the
   // direction at its inaccessible setting; the access-pin-dependent load follows.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         p3_reg <= reset_value(RST_ZERO); // [R2]
      end
      else if (reset_load)
      begin
         p3_reg <= reset_value(ea_level ? RST_ZERO : P3_RST_EA_LOW); // [R2] [R3] [R4]
      end
      else if (wr_en)
      begin
         case (paddr)
            OFS_P3_DATA: p3_reg.data <= pwdata[7:0] & P3_MASK;
            OFS_P3_DIR: p3_reg.dir <= pwdata[7:0] & P3_MASK;
            OFS_P3_FSEL: p3_reg.fsel <= pwdata[7:0] & P3_MASK;
            OFS_P3_RMW: p3_reg.data <= rmw_result(p3_read, pwdata, P3_MASK); // [R6]
            default: p3_reg <= p3_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         p4_reg <= reset_value(RST_ZERO);
      end
      else if (reset_load)
      begin
         p4_reg <= reset_value(ea_level ? RST_ZERO : P4_RST_EA_LOW); // [R10]
      end
      else if (wr_en)
      begin
         case (paddr)
            OFS_P4_DATA: p4_reg.data <= pwdata[7:0];
            OFS_P4_DIR: p4_reg.dir <= pwdata[7:0];
            OFS_P4_FSEL: p4_reg.fsel <= pwdata[7:0];
            OFS_P4_RMW: p4_reg.data <= rmw_result(p4_read, pwdata, P4_MASK); // [R6]
            default: p4_reg <= p4_reg;
         endcase
      end
   end

   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         p6_reg <= reset_value(RST_ZERO);
      end
      else if (reset_load)
      begin
         p6_reg <= reset_value(RST_ZERO); // [R15]
      end
      else if (wr_en)
      begin
         case (paddr)
            OFS_P6_DATA: p6_reg.data <= pwdata[7:0] & P6_MASK;
            OFS_P6_DIR: p6_reg.dir <= pwdata[7:0] & P6_MASK;
            OFS_P6_FSEL: p6_reg.fsel <= pwdata[7:0] & P6_MASK;
            OFS_P6_RMW: p6_reg.data <= rmw_result(p6_read, pwdata, P6_MASK); // [R6]
            default: p6_reg <= p6_reg;
         endcase
      end
   end

   // Pin drive per bit; unimplemented bits never drive and never pull up.
   genvar g;
   generate
      for (g = 0; g < 8; g++)
      begin : g_pins
         always_comb
         begin
            port_three_pins.oe[g] = p3_reg.dir[g] & P3_MASK[g];
            port_three_pins.out[g] = p3_reg.fsel[g] ? port_three_alt_out[g] : p3_reg.data[g];
            port_three_pins.pull_up[g] = ~p3_reg.dir[g] & p3_reg.fsel[g] & P3_MASK[g]; // [R9]
            port_four_pins.oe[g] = p4_reg.dir[g]; // [R7]
            port_four_pins.out[g] = p4_reg.fsel[g] ? ext_mem_addr[g] : p4_reg.data[g]; // [R7] [R8]
            port_four_pins.pull_up[g] = ~p4_reg.dir[g] & p4_reg.fsel[g]; // [R9]
            port_six_pins.oe[g] = p6_reg.dir[g] & P6_MASK[g];
            port_six_pins.out[g] = p6_reg.data[g] & ~p6_reg.fsel[g]; // [R12] [R14]
            port_six_pins.pull_up[g] = ~p6_reg.dir[g] & p6_reg.fsel[g] & P6_MASK[g]; // [R9]
         end
      end
   endgenerate

   // Interrupt inputs share the ordinary input path and are blocked while driving.
   assign ext_interrupt_in_zero = port_six_pin_in[0] & ~p6_reg.dir[0]; // [R13]
   assign ext_interrupt_in_one = port_six_pin_in[1] & ~p6_reg.dir[1]; // [R13]
   assign ext_interrupt_in_two = port_six_pin_in[2] & ~p6_reg.dir[2]; // [R13]
   assign ext_interrupt_in_three = port_six_pin_in[3] & ~p6_reg.dir[3]; // [R13]

   always_comb
   begin
      rd_hit = 1'b1;
      case (paddr)
         OFS_P3_DATA: rd_sel = p3_read;
         OFS_P3_DIR: rd_sel = p3_reg.dir;
         OFS_P3_FSEL: rd_sel = p3_reg.fsel;
         OFS_P4_DATA: rd_sel = p4_read;
         OFS_P4_DIR: rd_sel = p4_reg.dir;
         OFS_P4_FSEL: rd_sel = p4_reg.fsel;
         OFS_P6_DATA: rd_sel = p6_read;
         OFS_P6_DIR: rd_sel = p6_reg.dir;
         OFS_P6_FSEL: rd_sel = p6_reg.fsel;
         OFS_P3_RMW: rd_sel = p3_read;
         OFS_P4_RMW: rd_sel = p4_read;
         OFS_P6_RMW: rd_sel = p6_read;
         OFS_STATUS:
         begin
            rd_sel = 8'h00;
            rd_sel[STAT_EA_BIT] = ea_sample_reg;
            rd_sel[STAT_P3_LOCK_BIT] = ~p3_reg.dir[P3_GUARDED_BIT]; // [R1]
         end
         default:
         begin
            rd_sel = 8'h00;
            rd_hit = 1'b0;
         end
      endcase
   end

   // Read data is captured in the setup cycle so that it leaves a flip-flop.
   always_ff @(posedge ref_clk or posedge rst)
   begin
      if (rst)
      begin
         prdata_reg <= 32'h0000_0000;
      end
      else if (psel & ~penable)
      begin
         prdata_reg <= {24'h00_0000, rd_sel}; // [R18]
      end
   end

   assign prdata = prdata_reg;
   assign pready = psel & penable;
   assign pslverr = psel & penable & ~rd_hit;

endmodule

// [sim/pin_partner.sv]
module pin_partner
   import multi_port_io_pkg::*;
(
   input wire pin_drive_t pins,
   input wire logic [7:0] noise,
   output logic [7:0] level
);
   timeunit 1ns;
   timeprecision 1ns;
   // A floating pin gets a changing pattern, so a read never matches by luck.
   assign level = (pins.oe & pins.out) | (~pins.oe & (pins.pull_up | noise));
endmodule

// [sim/multi_port_io_assertions.sv]
module multi_port_io_assertions
   import multi_port_io_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic break_instruction,
   input wire logic watchdog_overflow,
   input wire logic opcode_trap,
   input wire logic external_access_pin,
   input wire logic psel,
   input wire logic penable,
   input wire logic [7:0] paddr,
   input wire logic pslverr,
   input wire logic [7:0] ext_mem_addr,
   input wire logic [7:0] port_six_pin_in,
   input wire pin_drive_t port_three_pins,
   input wire pin_drive_t port_four_pins,
   input wire pin_drive_t port_six_pins,
   input wire logic ext_interrupt_in_zero,
   input wire logic ext_interrupt_in_one,
   input wire logic ext_interrupt_in_two,
   input wire logic ext_interrupt_in_three
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);
   a_unmapped_err: assert property (psel && !penable && paddr > OFS_STATUS ##1 penable |-> pslverr)
      else $error("unmapped access without error");
   a_irq_input: assert property ({ext_interrupt_in_three, ext_interrupt_in_two, ext_interrupt_in_one,
      ext_interrupt_in_zero} == (port_six_pin_in[3:0] & ~port_six_pins.oe[3:0])) else $error("irq path wrong");
   a_pull_input: assert property (((port_four_pins.pull_up & port_four_pins.oe) |
      (port_six_pins.pull_up & port_six_pins.oe)) == 8'h00) else $error("pull-up on driven pin");
   a_p4_ea_low: assert property ($fell(rst) && !external_access_pin |=> port_four_pins.oe == 8'hff)
      else $error("port four not output after reset");
   a_p4_addr_out: assert property ($fell(rst) && !external_access_pin |=> port_four_pins.out == ext_mem_addr)
      else $error("port four not carrying address");
   a_p3_ea_low: assert property ($fell(rst) && !external_access_pin |=> port_three_pins.oe == 8'h02)
      else $error("port three reset wrong");
   a_ea_high_in: assert property ($fell(rst) && external_access_pin |=> (port_four_pins.oe | port_three_pins.oe) == 0)
      else $error("ports driven after reset");
   a_p6_reset: assert property ($fell(rst) |=> port_six_pins.oe == 8'h00 && port_six_pins.pull_up == 8'h00)
      else $error("port six reset wrong");
   a_guard_bit: assert property ($fell(rst) |=> !port_three_pins.oe[P3_GUARDED_BIT])
      else $error("guarded bit accessible after reset");
   a_sync_reload: assert property (break_instruction || watchdog_overflow || opcode_trap
      |=> port_six_pins.oe == 8'h00 && !port_three_pins.oe[P3_GUARDED_BIT]) else $error("sync reset missed");
endmodule
bind multi_port_io_block multi_port_io_assertions chk (.*);

// [sim/multi_port_io_block_tb.sv]
module multi_port_io_block_tb
   import multi_port_io_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic ref_clk = 0, rst = 1, break_instruction = 0, watchdog_overflow = 0, opcode_trap = 0;
   logic external_access_pin = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, busy = 0, e = 0;
   logic ext_interrupt_in_zero, ext_interrupt_in_one, ext_interrupt_in_two, ext_interrupt_in_three;
   logic [7:0] paddr = 0, ext_mem_addr = 0, port_three_alt_out = 0, n3 = 0, n4 = 0, n6 = 0;
   logic [7:0] port_three_pin_in, port_four_pin_in, port_six_pin_in;
   logic [31:0] pwdata = 0, prdata, r;
   pin_drive_t port_three_pins, port_four_pins, port_six_pins;
   logic [7:0] dat[3], dir[3], fsel[3];
   logic [7:0] msk[3] = '{P3_MASK, P4_MASK, P6_MASK};
   int seed = 59097, mismatches = 0, compares = 0;
   multi_port_io_block DUT (.*);
   pin_partner far3 (.pins(port_three_pins), .noise(n3), .level(port_three_pin_in));
   pin_partner far4 (.pins(port_four_pins), .noise(n4), .level(port_four_pin_in));
   pin_partner far6 (.pins(port_six_pins), .noise(n6), .level(port_six_pin_in));
   always #50 ref_clk = ~ref_clk;
   // Pins hold still during a transfer so the expected read is well defined.
   always @(posedge ref_clk)
   begin
      if (!busy)
      begin
         {n3, n4, n6, ext_mem_addr} <= $random(seed);
         port_three_alt_out <= $random(seed);
      end
   end
   task automatic close_out;
      $display("compares %0d mismatches %0d", compares, mismatches);
      if (mismatches == 0 && compares > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      compares++;
      if (g !== e)
      begin
         mismatches++;
         $display("[ERR] %0t: read %h, expected %h", $time, g, e);
      end
   endtask
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      n = 0;
      busy = 1;
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1;
      @(posedge ref_clk);
      while (pready !== 1'b1 && n++ < 20) @(posedge ref_clk);
      if (n > 20) mismatches++;
      r = prdata;
      e = pslverr;
      psel <= 0;
      penable <= 0;
      @(posedge ref_clk);
      busy = 0;
   endtask
   function automatic void mreset(input logic ea);
      dat = '{3{8'h00}};
      dir = '{ea ? RST_ZERO : P3_RST_EA_LOW, ea ? RST_ZERO : P4_RST_EA_LOW, RST_ZERO};
      fsel = dir;
   endfunction
   function automatic logic [7:0] mread(input int p);
      logic [7:0] pin;
      pin = p == 0 ? port_three_pin_in : p == 1 ? port_four_pin_in : port_six_pin_in;
      return ((pin & ~dir[p]) | (dat[p] & dir[p])) & msk[p] & ~(p == 2 ? dir[p] & fsel[p] : 8'h00);
   endfunction
   task automatic check_all;
      for (int p = 0; p < 3; p++)
      begin
         apb(0, 8'(12 * p), 0);
         chk(r, {24'h0, mread(p)});
         apb(0, 8'(12 * p + 4), 0);
         chk(r, {24'h0, dir[p] & msk[p]});
         apb(0, 8'(12 * p + 8), 0);
         chk(r, {24'h0, fsel[p] & msk[p]});
      end
   endtask
   task automatic do_reset(input logic ea);
      external_access_pin <= ea;
      rst <= 1;
      repeat (8) @(posedge ref_clk);
      rst <= 0;
      repeat (2) @(posedge ref_clk);
      mreset(ea);
   endtask
   initial
   begin
      int p, k;
      logic [7:0] v, m;
      logic [1:0] op;
      do_reset(0);
      check_all;
      // After reset the guarded bit is still inaccessible and the access pin was sampled low.
      apb(0, OFS_STATUS, 0);
      chk(r, 32'h0000_0002);
      for (int i = 0; i < 48; i++)
      begin
         p = i % 3;
         k = (i / 3) % 4;
         op = 2'(i / 12);
         v = 8'($random(seed));
         if (k == 1 && p == 0) v[P3_GUARDED_BIT] = 1'b1;
         apb(1, 8'(12 * p + 4 * (k % 3)) + (k == 3 ? OFS_P3_RMW - 8'(8 * p) : 8'h00), {22'h0, op, v});
         m = mread(p);
         case (k)
            0: dat[p] = v & msk[p];
            1: dir[p] = v;
            2: fsel[p] = v;
            default: dat[p] = msk[p] & (op == RMW_OR ? m | v : op == RMW_ANDN ? m & ~v : op == RMW_XOR ? m ^ v : m + v);
         endcase
         apb(0, 8'(12 * p), 0);
         chk(r, {24'h0, mread(p)});
      end
      apb(1, 8'h34, 32'hff);
      apb(0, 8'h34, 0);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h0000_0001);
      // Software has since set the guarded direction bit, so the lock flag is clear.
      apb(0, OFS_STATUS, 0);
      chk(r, 32'h0000_0000);
      chk({31'h0, e}, 32'h0000_0000);
      check_all;
      for (int s = 0; s < 3; s++)
      begin
         external_access_pin <= (s == 1);
         {opcode_trap, watchdog_overflow, break_instruction} <= 3'(1 << s);
         @(posedge ref_clk);
         {opcode_trap, watchdog_overflow, break_instruction} <= 3'h0;
         @(posedge ref_clk);
         mreset(s == 1);
         check_all;
      end
      do_reset(1);
      check_all;
      close_out;
   end
   initial
   begin
      #2000000;
      mismatches++;
      close_out;
   end
endmodule
